// file: srx_pkg.sv
// Constants for the receiver read-back, audio port and power-down registers.
// Assumes that the serial control port has already decoded register accesses.
`default_nettype none
package srx_pkg;
  // --------------------------------------------------------------------
  // Register addresses and reset values
  // --------------------------------------------------------------------
  localparam logic [6:0] SRX_ADDR_AUDIO_RX_FORMAT = 7'h1c;
  localparam logic [6:0] SRX_ADDR_READBACK_CONFIG = 7'h1d;
  localparam logic [6:0] SRX_ADDR_POWER_DOWN = 7'h1e;
  localparam logic [7:0] SRX_RST_AUDIO_RX_FORMAT = 8'h06;
  localparam logic [7:0] SRX_RST_READBACK_CONFIG = 8'h80;
  localparam logic [7:0] SRX_RST_POWER_DOWN = 8'h07;
  localparam logic [7:0] SRX_POWER_DOWN_USED = 8'h0f;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int SRX_FMT_WL_LO = 2;
  localparam int SRX_FMT_MASTER = 6;
  localparam int SRX_FMT_HOLDOVER = 7;
  localparam int SRX_RB_SEL_LO = 0;
  localparam int SRX_RB_CONTINUOUS_READBACK_ENABLE = 3;
  localparam int SRX_RB_FLAG = 4;
  localparam int SRX_RB_GPO = 5;
  localparam int SRX_RB_BYPASS = 6;
  localparam int SRX_RB_192K = 7;
  localparam int SRX_PD_PLL = 0;
  localparam int SRX_PD_RX = 1;
  localparam int SRX_PD_TX = 2;
  localparam int SRX_PD_OSC = 3;

  // --------------------------------------------------------------------
  // Read-back selector codes and word-length codes
  // --------------------------------------------------------------------
  localparam logic [2:0] SRX_SEL_INT_STATUS = 3'h0;
  localparam logic [2:0] SRX_SEL_CS1 = 3'h1;
  localparam logic [2:0] SRX_SEL_CS2 = 3'h2;
  localparam logic [2:0] SRX_SEL_CS3 = 3'h3;
  localparam logic [2:0] SRX_SEL_CS4 = 3'h4;
  localparam logic [2:0] SRX_SEL_CS5 = 3'h5;
  localparam logic [2:0] SRX_SEL_RX_STATUS = 3'h6;
  localparam logic [1:0] SRX_WL_16 = 2'h0;
  localparam logic [1:0] SRX_WL_20 = 2'h1;
  localparam logic [23:0] SRX_KEEP_16 = 24'hffff00;
  localparam logic [23:0] SRX_KEEP_20 = 24'hfffff0;
  localparam logic [23:0] SRX_KEEP_24 = 24'hffffff;
endpackage : srx_pkg
`default_nettype wire

// file: srx_regs.sv
// Control registers for read-back selection, receiver options, audio port
// clock hold-over and block power-down, with their effects on the datapath.
// Assumes register accesses arrive already decoded on sys_clk, and that the
// high receiver pins come straight from package pins.
`default_nettype none
module srx_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data_q,
  output logic reg_rd_valid_q,
  input wire logic [7:0] int_status,
  input wire logic [7:0] chan_status_1,
  input wire logic [7:0] chan_status_2,
  input wire logic [7:0] chan_status_3,
  input wire logic [7:0] chan_status_4,
  input wire logic [7:0] chan_status_5,
  input wire logic [7:0] rx_status,
  output logic [7:0] status_readback_q,
  output logic continuous_readback_enable_q,
  output logic status_flag_stream_enable_q,
  input wire logic spdif_source_present,
  output logic audio_port_master_select_q,
  output logic audio_clk_drive_en_q,
  input wire logic [3:0] rx_high_pin_in,
  output logic [3:0] rx_high_data_q,
  input wire logic [3:0] gpo_level,
  output logic [3:0] general_output_pin_q,
  output logic [3:0] general_output_pin_oe_q,
  input wire logic rx_word_valid,
  input wire logic [23:0] rx_word,
  output logic rx_word_valid_q,
  output logic [23:0] rx_word_q,
  output logic high_rate_rx_enable_q,
  output logic pll_power_off_q,
  output logic receiver_power_off_q,
  output logic transmitter_power_off_q,
  output logic oscillator_power_off_q
);
  logic [7:0] audio_rx_format_q;
  logic [7:0] receiver_readback_config_q;
  logic [7:0] block_power_down_q;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [2:0] readback_selector;
  logic truncation_bypass;
  logic rx_pins_as_outputs;
  logic [1:0] rx_word_length;
  logic [23:0] keep_mask;
  logic [7:0] selected_status;
  logic [7:0] reg_rd_d;

  assign readback_selector =
      receiver_readback_config_q[srx_pkg::SRX_RB_SEL_LO +: 3];
  assign truncation_bypass =
      receiver_readback_config_q[srx_pkg::SRX_RB_BYPASS];
  assign rx_pins_as_outputs = receiver_readback_config_q[srx_pkg::SRX_RB_GPO];
  assign rx_word_length = audio_rx_format_q[srx_pkg::SRX_FMT_WL_LO +: 2];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // Writes take effect at the edge that samples them.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_rx_format_q <= srx_pkg::SRX_RST_AUDIO_RX_FORMAT;
      receiver_readback_config_q <= srx_pkg::SRX_RST_READBACK_CONFIG;
      block_power_down_q <= srx_pkg::SRX_RST_POWER_DOWN;
    end else if (reg_wr_en) begin
      case (reg_addr)
        srx_pkg::SRX_ADDR_AUDIO_RX_FORMAT: begin
          audio_rx_format_q <= reg_wr_data;
        end
        srx_pkg::SRX_ADDR_READBACK_CONFIG: begin
          receiver_readback_config_q <= reg_wr_data;
        end
        srx_pkg::SRX_ADDR_POWER_DOWN: begin
          // Bits above the oscillator bit belong to other blocks here.
          block_power_down_q <= reg_wr_data & srx_pkg::SRX_POWER_DOWN_USED;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------

  // Unmapped addresses read as zero so software never sees stale data.
  always_comb begin
    case (reg_addr)
      srx_pkg::SRX_ADDR_AUDIO_RX_FORMAT: reg_rd_d = audio_rx_format_q;
      srx_pkg::SRX_ADDR_READBACK_CONFIG: reg_rd_d = receiver_readback_config_q;
      srx_pkg::SRX_ADDR_POWER_DOWN: reg_rd_d = block_power_down_q;
      default: reg_rd_d = 8'h00;
    endcase
  end

  // Read data is registered and valid for one cycle after the request.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data_q <= 8'h00;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data_q <= reg_rd_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status read-back selection
  // ----------------------------------------------------------------------

  // The unused code 111 returns zero rather than repeating another source.
  always_comb begin
    case (readback_selector)
      srx_pkg::SRX_SEL_INT_STATUS: selected_status = int_status;
      srx_pkg::SRX_SEL_CS1: selected_status = chan_status_1;
      srx_pkg::SRX_SEL_CS2: selected_status = chan_status_2;
      srx_pkg::SRX_SEL_CS3: selected_status = chan_status_3;
      srx_pkg::SRX_SEL_CS4: selected_status = chan_status_4;
      srx_pkg::SRX_SEL_CS5: selected_status = chan_status_5;
      srx_pkg::SRX_SEL_RX_STATUS: selected_status = rx_status;
      default: selected_status = 8'h00;
    endcase
  end

  // Mode flags and status word are registered so outputs come from flops.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_readback_q <= 8'h00;
      continuous_readback_enable_q <= 1'b0;
      status_flag_stream_enable_q <= 1'b0;
      high_rate_rx_enable_q <= 1'b1;
    end else begin
      status_readback_q <= selected_status;
      continuous_readback_enable_q <=
          receiver_readback_config_q[srx_pkg::SRX_RB_CONTINUOUS_READBACK_ENABLE];
      status_flag_stream_enable_q <=
          receiver_readback_config_q[srx_pkg::SRX_RB_FLAG];
      high_rate_rx_enable_q <=
          receiver_readback_config_q[srx_pkg::SRX_RB_192K];
    end
  end

  // ----------------------------------------------------------------------
  // Audio port clocks and power-down
  // ----------------------------------------------------------------------

  // In slave mode the clocks are inputs, so the drive enable stays low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      audio_port_master_select_q <= 1'b0;
      audio_clk_drive_en_q <= 1'b0;
    end else begin
      audio_port_master_select_q <=
          audio_rx_format_q[srx_pkg::SRX_FMT_MASTER];
      audio_clk_drive_en_q <= audio_rx_format_q[srx_pkg::SRX_FMT_MASTER] &&
          (spdif_source_present ||
           audio_rx_format_q[srx_pkg::SRX_FMT_HOLDOVER]);
    end
  end

  // Power-down levels pass one flop on their way to the analogue blocks.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pll_power_off_q <= 1'b1;
      receiver_power_off_q <= 1'b1;
      transmitter_power_off_q <= 1'b1;
      oscillator_power_off_q <= 1'b0;
    end else begin
      pll_power_off_q <= block_power_down_q[srx_pkg::SRX_PD_PLL];
      receiver_power_off_q <= block_power_down_q[srx_pkg::SRX_PD_RX];
      transmitter_power_off_q <=
          block_power_down_q[srx_pkg::SRX_PD_TX];
      oscillator_power_off_q <=
          block_power_down_q[srx_pkg::SRX_PD_OSC];
    end
  end

  // ----------------------------------------------------------------------
  // Shared receiver pins 4 to 7
  // ----------------------------------------------------------------------

  // Pin levels are asynchronous, so they pass two flops before any use.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= rx_high_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // A pin driven as an output is not also fed to the receiver.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_high_data_q <= 4'h0;
      general_output_pin_q <= 4'h0;
      general_output_pin_oe_q <= 4'h0;
    end else begin
      rx_high_data_q <= rx_pins_as_outputs ? 4'h0 : pin_sync_q;
      general_output_pin_q <= rx_pins_as_outputs ? gpo_level : 4'h0;
      general_output_pin_oe_q <= {4{rx_pins_as_outputs}};
    end
  end

  // ----------------------------------------------------------------------
  // Received word truncation
  // ----------------------------------------------------------------------

  // Codes 10 and 11 both mean a full 24-bit word.
  always_comb begin
    case (rx_word_length)
      srx_pkg::SRX_WL_16: keep_mask = srx_pkg::SRX_KEEP_16;
      srx_pkg::SRX_WL_20: keep_mask = srx_pkg::SRX_KEEP_20;
      default: keep_mask = srx_pkg::SRX_KEEP_24;
    endcase
  end

  // A powered-down receiver raises no word valid, though rx_word_q still loads each word.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_word_valid_q <= 1'b0;
      rx_word_q <= 24'h000000;
    end else begin
      rx_word_valid_q <= rx_word_valid &&
          !block_power_down_q[srx_pkg::SRX_PD_RX];
      if (rx_word_valid) begin
        rx_word_q <= truncation_bypass ? rx_word
                                       : (rx_word & keep_mask);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_HOLDOVER_STOP: assert property (
    audio_rx_format_q[7] && !audio_rx_format_q[6] |=> !audio_clk_drive_en_q)
    else $error("Clocks driven in slave mode.");
  AST_HOLDOVER_LOSS: assert property (
    audio_rx_format_q[6] && !audio_rx_format_q[7] && !spdif_source_present
    |=> !audio_clk_drive_en_q)
    else $error("Clocks kept after source loss without hold-over.");
  // The sampled reset keeps the release edge, whose flop still held its
  // reset value, out of the selector checks.
  AST_SEL_INT: assert property (
    !rst && readback_selector == 3'h0 |=>
    status_readback_q == $past(int_status))
    else $error("Code 000 did not return interrupt status.");
  AST_SEL_RX: assert property (
    !rst && readback_selector == 3'h6 |=>
    status_readback_q == $past(rx_status))
    else $error("Code 110 did not return receiver status.");
  AST_SEL_CS: assert property (
    !rst && readback_selector == 3'h3 |=>
    status_readback_q == $past(chan_status_3))
    else $error("Code 011 did not return channel status 3.");
  AST_CONTINUOUS_READBACK_ENABLE: assert property (
    reg_wr_en && reg_addr == 7'h1d |=> ##1
    continuous_readback_enable_q == $past(reg_wr_data[3], 2))
    else $error("Continuous read-back flag did not follow write.");
  AST_FLAG: assert property (
    $rose(receiver_readback_config_q[4]) |=> status_flag_stream_enable_q)
    else $error("Flag stream mode not enabled.");
  AST_GPO: assert property (
    !rx_pins_as_outputs |=> general_output_pin_oe_q == 4'h0 &&
    general_output_pin_q == 4'h0)
    else $error("Receiver pins driven while inputs.");
  AST_TRUNC: assert property (
    rx_word_valid && !truncation_bypass && rx_word_length == 2'h0
    |=> rx_word_q[7:0] == 8'h00)
    else $error("16-bit word not truncated.");
  AST_BYPASS: assert property (
    rx_word_valid && truncation_bypass |=> rx_word_q == $past(rx_word))
    else $error("Bypassed word was altered.");
  AST_RATE: assert property (
    high_rate_rx_enable_q == $past(receiver_readback_config_q[7]))
    else $error("High rate enable does not follow bit 7.");
  AST_RX_OFF: assert property (
    block_power_down_q[1] |=> !rx_word_valid_q && receiver_power_off_q)
    else $error("Receiver active while powered down.");
  AST_TX_OFF: assert property (
    block_power_down_q[2] |=> transmitter_power_off_q)
    else $error("Transmitter not powered down.");
  AST_PLL_OSC: assert property (
    ##1 pll_power_off_q == $past(block_power_down_q[0]) &&
    oscillator_power_off_q == $past(block_power_down_q[3]))
    else $error("PLL or oscillator power state wrong.");
endmodule : srx_regs
`default_nettype wire

// file: test_srx_regs.sv
// Self-checking bench for the srx_regs control register block.
// Assumes the block alone, reached through its decoded strobe port at 25 MHz.
`default_nettype none
module test_srx_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] int_status = 8'h10;
  logic [7:0] chan_status_1 = 8'h21;
  logic [7:0] chan_status_2 = 8'h22;
  logic [7:0] chan_status_3 = 8'h23;
  logic [7:0] chan_status_4 = 8'h24;
  logic [7:0] chan_status_5 = 8'h25;
  logic [7:0] rx_status = 8'h36;
  logic spdif_source_present = 1'b1;
  logic [3:0] rx_high_pin_in = 4'h0;
  logic [3:0] gpo_level = 4'h0;
  logic rx_word_valid = 1'b0;
  logic [23:0] rx_word = 24'h000000;
  logic [7:0] rd_data, status_rb;
  logic rd_valid, continuous_readback_enable_en, flag_en, master, clk_en, rx_valid_q, high_rate;
  logic [3:0] rx_data, gpo_out, gpo_oe;
  logic [23:0] rx_word_out;
  logic pll_off, rx_off, tx_off, osc_off;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  srx_regs dut_u (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data_q(rd_data), .reg_rd_valid_q(rd_valid),
    .int_status(int_status), .chan_status_1(chan_status_1),
    .chan_status_2(chan_status_2), .chan_status_3(chan_status_3),
    .chan_status_4(chan_status_4), .chan_status_5(chan_status_5),
    .rx_status(rx_status), .status_readback_q(status_rb),
    .continuous_readback_enable_q(continuous_readback_enable_en),
    .status_flag_stream_enable_q(flag_en),
    .spdif_source_present(spdif_source_present),
    .audio_port_master_select_q(master), .audio_clk_drive_en_q(clk_en),
    .rx_high_pin_in(rx_high_pin_in), .rx_high_data_q(rx_data),
    .gpo_level(gpo_level), .general_output_pin_q(gpo_out),
    .general_output_pin_oe_q(gpo_oe), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .rx_word_valid_q(rx_valid_q), .rx_word_q(rx_word_out),
    .high_rate_rx_enable_q(high_rate), .pll_power_off_q(pll_off),
    .receiver_power_off_q(rx_off), .transmitter_power_off_q(tx_off),
    .oscillator_power_off_q(osc_off));

  // --------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // --------------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  // The whole run is about a hundred cycles, so 3000 means a hang.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Lands just after an edge, so registered outputs have settled.
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // The write is taken on the second edge; outputs move one edge later.
  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    step(1);
  endtask : wr

  task automatic rd_chk(logic [6:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("read valid", 24'h000001, {23'h0, rd_valid});
    chk("read data", {16'h0, exp}, {16'h0, rd_data});
  endtask : rd_chk

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic test_defaults();
    chk("status after reset", {16'h0, int_status}, {16'h0, status_rb});
    chk("high rate", 24'h1, {23'h0, high_rate});
    chk("powers", 24'h7, {20'h0, osc_off, tx_off, rx_off, pll_off});
    chk("continuous_readback_enable flag", 24'h0, {22'h0, continuous_readback_enable_en, flag_en});
    chk("pin oe", 24'h0, {20'h0, gpo_oe});
    rd_chk(7'h1c, 8'h06);
    rd_chk(7'h1d, 8'h80);
    rd_chk(7'h1e, 8'h07);
    rd_chk(7'h20, 8'h00);
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_selector();
    logic [7:0] exp;
    for (int k = 0; k < 8; k++) begin
      wr(7'h1d, 8'h80 | 8'(k));
      case (k)
        0: exp = int_status;
        1: exp = chan_status_1;
        2: exp = chan_status_2;
        3: exp = chan_status_3;
        4: exp = chan_status_4;
        5: exp = chan_status_5;
        6: exp = rx_status;
        default: exp = 8'h00;
      endcase
      chk("status readback", {16'h0, exp}, {16'h0, status_rb});
    end
    $display("test selector done");
  endtask : test_selector

  task automatic test_modes();
    wr(7'h1d, 8'h18);
    chk("continuous_readback_enable flag on", 24'h3, {22'h0, continuous_readback_enable_en, flag_en});
    chk("high rate off", 24'h0, {23'h0, high_rate});
    wr(7'h1d, 8'h90);
    chk("flag only", 24'h1, {22'h0, continuous_readback_enable_en, flag_en});
    chk("high rate on", 24'h1, {23'h0, high_rate});
    wr(7'h1e, 8'hf8);
    rd_chk(7'h1e, 8'h08);
    chk("powers", 24'h8, {20'h0, osc_off, tx_off, rx_off, pll_off});
    wr(7'h1e, 8'h05);
    chk("powers", 24'h5, {20'h0, osc_off, tx_off, rx_off, pll_off});
    $display("test modes done");
  endtask : test_modes

  task automatic test_pins();
    @(posedge sys_clk);
    rx_high_pin_in <= 4'ha;
    gpo_level <= 4'h5;
    step(3);
    chk("pin input", 24'ha, {20'h0, rx_data});
    chk("pin oe off", 24'h0, {20'h0, gpo_oe});
    wr(7'h1d, 8'ha0);
    chk("pin oe on", 24'hf, {20'h0, gpo_oe});
    chk("pin out", 24'h5, {20'h0, gpo_out});
    chk("pin input blocked", 24'h0, {20'h0, rx_data});
    $display("test pins done");
  endtask : test_pins

  task automatic send_word(string name, logic [23:0] exp, logic vexp);
    @(posedge sys_clk);
    rx_word_valid <= 1'b1;
    rx_word <= 24'habcdef;
    @(posedge sys_clk);
    rx_word_valid <= 1'b0;
    #1;
    chk(name, {23'h0, vexp}, {23'h0, rx_valid_q});
    chk(name, exp, rx_word_out);
  endtask : send_word

  task automatic test_words();
    wr(7'h1e, 8'h07);
    send_word("word rx off", 24'habcde0, 1'b0);
    wr(7'h1e, 8'h05);
    send_word("word wl20", 24'habcde0, 1'b1);
    wr(7'h1c, 8'h0a);
    send_word("word wl24", 24'habcdef, 1'b1);
    wr(7'h1c, 8'h02);
    send_word("word wl16", 24'habcd00, 1'b1);
    wr(7'h1d, 8'hc0);
    send_word("word bypass", 24'habcdef, 1'b1);
    $display("test words done");
  endtask : test_words

  task automatic test_clocks();
    wr(7'h1c, 8'h46);
    chk("master", 24'h1, {23'h0, master});
    chk("drive present", 24'h1, {23'h0, clk_en});
    @(posedge sys_clk);
    spdif_source_present <= 1'b0;
    step(2);
    chk("drive lost", 24'h0, {23'h0, clk_en});
    wr(7'h1c, 8'hc6);
    chk("drive holdover", 24'h1, {23'h0, clk_en});
    wr(7'h1c, 8'h86);
    chk("drive slave", 24'h0, {23'h0, clk_en});
    $display("test clocks done");
  endtask : test_clocks

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    test_defaults();
    test_selector();
    test_modes();
    test_pins();
    test_words();
    test_clocks();
    finish_test();
  end
endmodule : test_srx_regs
`default_nettype wire
